// [css_consts.svh]
// Purpose: Named offsets, field positions and reset values of the completion framer.
// Assumes: Included by its bare name wherever the constants are needed.
// Notes:   Offsets are byte addresses on a 32-bit APB bus.
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

`define CSS_AW             12
`define CSS_REG_CTRL       12'h000
`define CSS_REG_STATUS     12'h004
`define CSS_REG_ABORTS     12'h008
`define CSS_REG_BEATS      12'h00c

`define CSS_CTRL_STRADDLE  0
`define CSS_CTRL_ENDPOINT  1
`define CSS_CTRL_RST       2'h0

`define CSS_STAT_HOLDING   0
`define CSS_STAT_OUT_VALID 1
`define CSS_STAT_STRADDLE  2

`define CSS_MIN_UP_LAST_DW 2'h2
`define CSS_CNT_RST        32'h0000_0000
`define CSS_CNT_STEP       32'h0000_0001
`define CSS_WIDE_BITS      256

`endif

// [css_pkg.sv]
// Purpose: Types shared by the completion framer and its bench.
// Assumes: Nothing beyond the constants header.
// Notes:   Packed struct fields run from the most significant bit down.
package css_pkg;

    // One half-beat segment from the completion buffer.
    typedef struct packed {
        logic [127:0] data;
        logic [15:0]  byte_en;
        logic [1:0]   last_dw;
        logic         sop;
        logic         eop;
        logic         err;
        logic         payload;
    } css_seg_t;

    // Sideband word, bit 0 of byte_en is bit 0 of the bus.
    typedef struct packed {
        logic [31:0] parity;
        logic        abort;
        logic [3:0]  end_b;
        logic [3:0]  end_a;
        logic        start_b;
        logic        start_a;
        logic [31:0] byte_en;
    } css_side_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } css_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } css_apb_rsp_t;

    typedef enum {
        CSS_HOLD,
        CSS_EMIT_ONE,
        CSS_EMIT_TWO
    } css_act_t;

endpackage : css_pkg

// [css_framer.sv]
// Purpose: Frames requester completions onto the completion stream with sideband flags.
// Assumes: Segments arrive in packet order, each packet opening with sop and closing with eop.
// Notes:   Straddling only takes effect with a 256-bit bus; change it only while idle.
//
// Contract
// [RULE_01] Unstraddled: start_a only in first beat
// [RULE_02] Unstraddled: one start per beat, start_b low
// [RULE_03] Straddle 256-bit: two completions may share beat
// [RULE_04] Straddle start_a: lane 0, or 16 if continuing
// [RULE_05] Second start only after end in bytes 0-15
// [RULE_06] end_a: flag bit 0, last-Dword offset bits 3:1
// [RULE_07] end_b: second end, offset only 6 or 7
// [RULE_08] end_b implies end_a and start_b
// [RULE_09] End fields meaningful only in straddle mode
// [RULE_10] Consumer finds second end from length or enables
// [RULE_11] Payload read error raises abort in final beat; code drops an upper completion's error after a clean lower end
// [RULE_12] Consumer drops whole aborted completion
// [RULE_13] No abort without payload; only with end_a
// [RULE_14] No second start in an abort beat
// [RULE_15] Endpoint reports the payload error upstream
// [RULE_16] Bits 74:43 carry odd parity per byte
// [RULE_17] Narrow buses: unused parity bits held zero
// [RULE_18] Consumer may ignore start_a outside straddle
// [RULE_19] Transfer on valid and accept; hold while stalled
// [RULE_20] Straddle mode holds packet-last at zero
// [RULE_21] Byte enables mark payload bytes, never descriptors
// [RULE_22] Offset n means bytes 4n to 4n+3
`include "css_consts.svh"

module css_framer
    import css_pkg::*;
#(
    parameter int BUS_W  = 256,
    parameter int KEEP_W = BUS_W / 32
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    // Register bus
    input  wire css_apb_req_t       apb_req,
    output css_apb_rsp_t            apb_rsp,
    // Segments from the completion buffer
    input  wire logic               seg_valid,
    input  wire css_seg_t           seg_in,
    output logic                    seg_ready,
    // Completion stream
    output logic                    completion_valid,
    input  wire logic               completion_accept,
    output logic [BUS_W-1:0]        completion_data_bus,
    output logic [KEEP_W-1:0]       completion_dword_keep,
    output logic                    completion_packet_last,
    output css_side_t               completion_sideband_bus,
    // Error reporting
    output logic                    aer_uncorr_report
);

    // Narrower buses carry one whole segment per beat and never straddle.
    localparam bit WIDE   = (BUS_W == `CSS_WIDE_BITS);
    localparam int NBYTES = BUS_W / 8;

    // Control and status state.
    logic               ctrl_straddle_q;
    logic               ctrl_endpoint_q;
    logic [31:0]        abort_cnt_q;
    logic [31:0]        beat_cnt_q;
    logic               straddle;

    // Packing state.
    css_seg_t           lo_q;
    logic               lo_full_q;
    logic               lo_full_d;
    logic               seg_ready_q;
    css_act_t           act;
    logic               fire;
    logic               out_free;
    logic               lo_abort;
    logic               up_fits;
    logic               pairable;

    // Beat under construction.
    logic               up_v;
    logic               up_end;
    logic               any_end;
    logic [2:0]         end_idx;
    logic [255:0]       wide_data;
    logic [31:0]        be_all;
    css_side_t          side_d;
    logic [KEEP_W-1:0]  keep_d;
    logic               last_d;

    // Output registers.
    logic               out_valid_q;
    logic               out_valid_d;
    logic [BUS_W-1:0]   out_data_q;
    logic [KEEP_W-1:0]  out_keep_q;
    logic               out_last_q;
    css_side_t          out_side_q;
    logic               aer_q;
    logic               xfer;

    // Register bus answer.
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;
    logic [31:0]        rd_mux;
    logic               rd_hit;
    logic               apb_setup;
    logic               apb_done;

    assign straddle = WIDE & ctrl_straddle_q;
    assign fire     = seg_valid & seg_ready_q;
    // The output register is free when it is empty or its beat leaves now.
    assign out_free = ~out_valid_q | completion_accept;
    assign xfer     = out_valid_q & completion_accept;

    // Decide whether the held lower segment can take an upper partner.
    always_comb begin
        lo_abort = lo_q.eop & lo_q.err & lo_q.payload;
        up_fits  = ~seg_in.eop | (seg_in.last_dw >= `CSS_MIN_UP_LAST_DW);
        pairable = 1'b0;

        if (WIDE) begin
            // A continuing lower segment must be completed by the next one.
            if (!lo_q.eop) begin
                pairable = 1'b1;
            end else if (straddle && seg_in.sop && !lo_abort && up_fits) begin // [RULE_03] [RULE_05] [RULE_14]
                // A completion that both starts and ends above a continuation is
                // deferred, so that a second end always comes with two starts.
                pairable = lo_q.sop | ~seg_in.eop; // [RULE_08]
            end
        end
    end

    // A lower segment that ends a completion leaves without waiting for a
    // partner, trading some straddle density for lower latency.
    always_comb begin
        if (!lo_full_q || !out_free) begin
            act = CSS_HOLD;
        end else if (WIDE && fire && pairable) begin
            act = CSS_EMIT_TWO;
        end else if (!WIDE || lo_q.eop) begin
            act = CSS_EMIT_ONE;
        end else begin
            act = CSS_HOLD;
        end
    end

    // Occupancy of the lower slot and validity of the next output beat.
    always_comb begin
        unique case (act)
            CSS_HOLD:     lo_full_d = lo_full_q | fire;
            CSS_EMIT_ONE: lo_full_d = fire;
            CSS_EMIT_TWO: lo_full_d = 1'b0;
        endcase

        // An unaccepted beat stays valid; nothing is dropped while stalled.
        if (act != CSS_HOLD) begin
            out_valid_d = 1'b1;
        end else begin
            out_valid_d = out_valid_q & ~completion_accept; // [RULE_19]
        end
    end

    // Build the beat from the held segment and, when paired, the incoming one.
    always_comb begin
        up_v    = (act == CSS_EMIT_TWO);
        up_end  = up_v & seg_in.eop;
        any_end = lo_q.eop | up_end;
        if (lo_q.eop) begin
            end_idx = {1'b0, lo_q.last_dw}; // [RULE_22]
        end else begin
            end_idx = {1'b1, seg_in.last_dw}; // [RULE_22]
        end

        wide_data = {(up_v ? seg_in.data : 128'h0), lo_q.data};
        be_all    = {(up_v ? seg_in.byte_en : 16'h0), lo_q.byte_en};
        side_d    = '0;

        // Parity is formed on the muxed beat, so an empty upper half still
        // reads as odd parity on every byte.
        for (int i = 0; i < NBYTES; i++) begin
            side_d.byte_en[i] = be_all[i]; // [RULE_21]
            side_d.parity[i]  = ~^wide_data[8*i +: 8]; // [RULE_16] [RULE_17]
        end

        side_d.start_a = lo_q.sop | (up_v & seg_in.sop); // [RULE_01] [RULE_04]
        side_d.start_b = straddle & lo_q.sop & up_v & seg_in.sop; // [RULE_02] [RULE_05]

        if (any_end) begin
            side_d.end_a = {end_idx, 1'b1}; // [RULE_06]
        end
        if (straddle && lo_q.eop && up_end) begin
            side_d.end_b = {1'b1, seg_in.last_dw, 1'b1}; // [RULE_07] [RULE_08] [RULE_09]
        end

        if (lo_q.eop) begin
            side_d.abort = lo_abort; // [RULE_11] [RULE_13]
        end else begin
            side_d.abort = up_end & seg_in.err & seg_in.payload; // [RULE_11] [RULE_13]
        end

        // In straddle mode keep stays all ones; the sideband flags frame packets.
        for (int k = 0; k < KEEP_W; k++) begin
            keep_d[k] = straddle | ~any_end | (k[2:0] <= end_idx);
        end
        last_d = ~straddle & any_end; // [RULE_20]
    end

    // Held lower segment; a paired segment goes straight into the upper half
    // of the beat and is never held.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lo_q      <= '0;
            lo_full_q <= 1'b0;
        end else begin
            lo_full_q <= lo_full_d;
            if (fire && act != CSS_EMIT_TWO) begin
                lo_q <= seg_in;
            end
        end
    end

    // Ready looks one cycle ahead so that it can come from a flop.
    // It may drop a cycle early, costing a bubble but never a lost segment.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            seg_ready_q <= 1'b0;
        end else begin
            seg_ready_q <= ~lo_full_d | ~out_valid_d;
        end
    end

    // Output beat register; it only reloads once the consumer has taken it.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
            out_keep_q  <= '0;
            out_last_q  <= 1'b0;
            out_side_q  <= '0;
        end else begin
            out_valid_q <= out_valid_d; // [RULE_19]
            if (act != CSS_HOLD) begin
                out_data_q <= wide_data[BUS_W-1:0];
                out_keep_q <= keep_d;
                out_last_q <= last_d;
                out_side_q <= side_d;
            end else if (xfer) begin
                // A taken beat drops last at once, so a stale last cannot
                // linger into a later switch to straddle mode.
                out_last_q <= 1'b0; // [RULE_20]
            end
        end
    end

    // Error report toward the upstream port, one pulse per aborted completion.
    // The pulse follows the transfer, so a stalled abort beat reports once.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            aer_q <= 1'b0;
        end else begin
            aer_q <= xfer & out_side_q.abort & ctrl_endpoint_q; // [RULE_15]
        end
    end

    // Beat and abort counters, both wrap.
    // Counting at the transfer keeps stalled cycles out of the totals.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            abort_cnt_q <= `CSS_CNT_RST;
            beat_cnt_q  <= `CSS_CNT_RST;
        end else if (xfer) begin
            beat_cnt_q <= beat_cnt_q + `CSS_CNT_STEP;
            if (out_side_q.abort) begin
                abort_cnt_q <= abort_cnt_q + `CSS_CNT_STEP;
            end
        end
    end

    // APB slave: the answer is prepared in the setup cycle, so every access
    // completes in its first access cycle with no wait state.
    assign apb_setup = apb_req.psel & ~apb_req.penable;
    assign apb_done  = apb_req.psel & apb_req.penable & pready_q;

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;

        // Reads return the state as it stands at the setup edge.
        unique case (apb_req.paddr)
            `CSS_REG_CTRL: begin
                rd_mux[`CSS_CTRL_STRADDLE] = ctrl_straddle_q;
                rd_mux[`CSS_CTRL_ENDPOINT] = ctrl_endpoint_q;
            end
            `CSS_REG_STATUS: begin
                rd_mux[`CSS_STAT_HOLDING]   = lo_full_q;
                rd_mux[`CSS_STAT_OUT_VALID] = out_valid_q;
                rd_mux[`CSS_STAT_STRADDLE]  = straddle;
            end
            `CSS_REG_ABORTS: rd_mux = abort_cnt_q;
            `CSS_REG_BEATS:  rd_mux = beat_cnt_q;
            default:         rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= apb_setup;
            // The error flag is latched with the read data so both stand until the next setup.
            if (apb_setup) begin
                prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_q <= ~rd_hit;
            end
        end
    end

    // Control register; straddling is sampled by the packer every cycle, so
    // flipping it inside a packet would break that packet's framing.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_straddle_q <= 1'(`CSS_CTRL_RST >> `CSS_CTRL_STRADDLE);
            ctrl_endpoint_q <= 1'(`CSS_CTRL_RST >> `CSS_CTRL_ENDPOINT);
        end else if (apb_done && apb_req.pwrite && apb_req.paddr == `CSS_REG_CTRL) begin
            ctrl_straddle_q <= apb_req.pwdata[`CSS_CTRL_STRADDLE];
            ctrl_endpoint_q <= apb_req.pwdata[`CSS_CTRL_ENDPOINT];
        end
    end

    // Every output comes straight from a flop.
    assign apb_rsp                 = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

    assign seg_ready               = seg_ready_q;
    assign completion_valid        = out_valid_q;
    assign completion_data_bus     = out_data_q;
    assign completion_dword_keep   = out_keep_q;
    assign completion_packet_last  = out_last_q;
    assign completion_sideband_bus = out_side_q;
    assign aer_uncorr_report       = aer_q;

endmodule : css_framer

// [css_framer_asserts.sv]
// Purpose: Concurrent checks on the completion framer ports.
// Assumes: Straddle and endpoint modes change only while the stream is idle.
// Notes:   Mode bits are tracked from APB writes to the control register.
`include "css_consts.svh"
module css_framer_asserts
    import css_pkg::*;
#(
    parameter int BUS_W  = 256,
    parameter int KEEP_W = BUS_W / 32
) (
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              reset_n,
    // Register bus
    input wire css_apb_req_t      apb_req,
    input wire css_apb_rsp_t      apb_rsp,
    // Segment input
    input wire logic              seg_valid,
    input wire css_seg_t          seg_in,
    input wire logic              seg_ready,
    // Completion stream
    input wire logic              completion_valid,
    input wire logic              completion_accept,
    input wire logic [BUS_W-1:0]  completion_data_bus,
    input wire logic [KEEP_W-1:0] completion_dword_keep,
    input wire logic              completion_packet_last,
    input wire css_side_t         completion_sideband_bus,
    input wire logic              aer_uncorr_report
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        strad_q;
    logic        ep_q;
    logic [31:0] par_exp;
    css_side_t   sb;
    assign sb = completion_sideband_bus;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strad_q <= 1'h0;
            ep_q    <= 1'h0;
        end else if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
                     && apb_req.paddr == `CSS_REG_CTRL) begin
            strad_q <= apb_req.pwdata[`CSS_CTRL_STRADDLE] && BUS_W == 256;
            ep_q    <= apb_req.pwdata[`CSS_CTRL_ENDPOINT];
        end
    end

    // Lanes above the bus width must read zero, so they keep the cleared value.
    always_comb begin
        par_exp = 32'h0;
        for (int i = 0; i < BUS_W / 8; i++) begin
            par_exp[i] = ~^completion_data_bus[8*i +: 8];
        end
    end

    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_start_b_idle: assert property (completion_valid && !strad_q |-> !sb.start_b)
        else $error("second start outside straddle mode");
    a_end_b_idle: assert property (completion_valid && !strad_q |-> sb.end_b == 4'h0)
        else $error("second end field set outside straddle mode");
    a_end_b_pair: assert property (completion_valid && sb.end_b[0] |-> sb.end_a[0] && sb.start_b)
        else $error("second end without first end and second start");
    a_end_b_offset: assert property (completion_valid && sb.end_b[0] |-> sb.end_b[3:1] >= 3'h6)
        else $error("second end offset below six");
    a_second_start: assert property (completion_valid && sb.start_b |-> sb.end_a[0] && sb.start_a)
        else $error("second start without an earlier end in the beat");
    a_abort_end: assert property (completion_valid && sb.abort |-> sb.end_a[0] && !sb.start_b)
        else $error("abort outside a final beat or beside a second start");
    a_stall_hold: assert property (completion_valid && !completion_accept |=> completion_valid
            && $stable(sb) && $stable(completion_data_bus) && $stable(completion_packet_last))
        else $error("stalled beat changed");
    a_last_straddle: assert property (strad_q |-> !completion_packet_last)
        else $error("packet last set in straddle mode");
    a_parity_odd: assert property (completion_valid |-> sb.parity == par_exp)
        else $error("parity bits wrong");
    a_aer_pulse: assert property (aer_uncorr_report ==
            $past(completion_valid && completion_accept && sb.abort && ep_q))
        else $error("error report pulse wrong");
    a_apb_ready: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("pready missing in first access cycle");
    a_keep_ones: assert property (completion_valid && strad_q
            |-> &completion_dword_keep)
        else $error("dword keep not all ones in straddle mode");
endmodule : css_framer_asserts

bind css_framer css_framer_asserts #(.BUS_W(BUS_W), .KEEP_W(KEEP_W)) chk_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .seg_valid(seg_valid), .seg_in(seg_in), .seg_ready(seg_ready),
    .completion_valid(completion_valid), .completion_accept(completion_accept),
    .completion_data_bus(completion_data_bus), .completion_dword_keep(completion_dword_keep),
    .completion_packet_last(completion_packet_last),
    .completion_sideband_bus(completion_sideband_bus), .aer_uncorr_report(aer_uncorr_report));

// [css_sink.sv]
// Purpose: Consumer of the completion stream that records every beat taken.
// Assumes: A 256-bit stream; at most sixteen beats are kept.
// Notes:   With slow set, accept drops every other cycle to force stalls.
module css_sink
    import css_pkg::*;
(
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    // Completion stream
    input  wire logic         completion_valid,
    input  wire logic [255:0] completion_data_bus,
    input  wire logic         completion_packet_last,
    input  wire css_side_t    completion_sideband_bus,
    output logic              completion_accept,
    // Pacing
    input  wire logic         slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [74:0]  side_q [16];
    logic         last_q [16];
    logic [255:0] data_q [16];
    int           beats;
    int           dropped;
    logic         phase_q;

    assign completion_accept = !(slow && phase_q);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= 1'h0;
            beats   <= 0;
            dropped <= 0;
        end else begin
            phase_q <= ~phase_q;
            if (completion_valid && completion_accept) begin
                // Byte enables are kept so the second end can be located.
                side_q[beats[3:0]] <= completion_sideband_bus;
                last_q[beats[3:0]] <= completion_packet_last;
                data_q[beats[3:0]] <= completion_data_bus;
                beats              <= beats + 1;
                dropped            <= dropped + int'(completion_sideband_bus.abort);
            end
        end
    end
endmodule : css_sink

// [tb_completion_stream_sideband.sv]
// Purpose: Self-checking bench for the completion framer at 256 bits.
// Assumes: One 200 MHz clock; the sink records beats in order.
// Notes:   Sideband compares cover bits 42:32 only; parity is left to the checker.
`include "css_consts.svh"
module tb_completion_stream_sideband
    import css_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         ref_clk;
    logic         reset_n;
    css_apb_req_t apb_req;
    css_apb_rsp_t apb_rsp;
    logic         seg_valid;
    css_seg_t     seg_in;
    logic         seg_ready;
    logic         completion_valid;
    logic         completion_accept;
    logic [255:0] completion_data_bus;
    logic [7:0]   completion_dword_keep;
    logic         completion_packet_last;
    css_side_t    completion_sideband_bus;
    logic         aer_uncorr_report;
    logic         slow;
    int           fails;
    int           compares;

    css_framer #(.BUS_W(256)) dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .seg_valid(seg_valid), .seg_in(seg_in), .seg_ready(seg_ready),
        .completion_valid(completion_valid), .completion_accept(completion_accept),
        .completion_data_bus(completion_data_bus), .completion_dword_keep(completion_dword_keep),
        .completion_packet_last(completion_packet_last),
        .completion_sideband_bus(completion_sideband_bus), .aer_uncorr_report(aer_uncorr_report));

    css_sink sink_u (.ref_clk(ref_clk), .reset_n(reset_n), .completion_valid(completion_valid),
        .completion_data_bus(completion_data_bus), .completion_packet_last(completion_packet_last),
        .completion_sideband_bus(completion_sideband_bus), .completion_accept(completion_accept),
        .slow(slow));

    task automatic complete_run;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                            output logic [31:0] rd, output logic err);
        apb_req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'h1, penable: 1'h0};
        @(posedge ref_clk);
        apb_req.penable <= 1'h1;
        do begin
            @(posedge ref_clk);
        end while (apb_rsp.pready !== 1'h1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'h0;
        apb_req.penable <= 1'h0;
        @(posedge ref_clk);
    endtask : apb_xfer

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] v;
        logic        e;
        apb_xfer(a, 1'h0, 32'h0, v, e);
        check("prdata", {224'h0, exp}, {224'h0, v});
        check("pslverr", {255'h0, eerr}, {255'h0, e});
    endtask : reg_rd

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        logic        e;
        apb_xfer(a, 1'h1, d, v, e);
    endtask : reg_wr

    // Flags are {sop, eop, err}; the task leaves valid high for back-to-back use.
    task automatic seg_send(input logic [2:0] f, input logic [1:0] ldw);
        seg_valid <= 1'h1;
        seg_in <= '{data: {4{f, ldw, 27'h5a3_ce17}}, byte_en: f[2] ? 16'hf000 : 16'hffff,
                    last_dw: ldw, sop: f[2], eop: f[1], err: f[0], payload: 1'h1};
        do begin
            @(posedge ref_clk);
        end while (seg_ready !== 1'h1);
    endtask : seg_send

    task automatic wait_beats(input int n);
        seg_valid <= 1'h0;
        while (sink_u.beats < n) @(posedge ref_clk);
    endtask : wait_beats

    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        #20000;
        fails++;
        complete_run();
    end

    initial begin
        reset_n  = 1'h0;
        apb_req  = '0;
        seg_valid = 1'h0;
        seg_in   = '0;
        slow     = 1'h0;
        fails    = 0;
        compares = 0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'h1;
        @(posedge ref_clk);
        reg_rd(`CSS_REG_CTRL, 32'h0, 1'h0);
        reg_rd(`CSS_REG_STATUS, 32'h0, 1'h0);
        reg_rd(`CSS_REG_ABORTS, 32'h0, 1'h0);
        reg_rd(`CSS_REG_BEATS, 32'h0, 1'h0);
        reg_rd(12'h010, 32'h0, 1'h1);
        $display("registers test done");
        seg_send(3'h4, 2'h0);
        seg_send(3'h2, 2'h3);
        seg_send(3'h6, 2'h1);
        wait_beats(2);
        check("side0", {1'h0, 4'h0, 4'hf, 1'h0, 1'h1}, sink_u.side_q[0][42:32]);
        check("last0", 256'h1, {255'h0, sink_u.last_q[0]});
        check("side1", {1'h0, 4'h0, 4'h3, 1'h0, 1'h1}, sink_u.side_q[1][42:32]);
        check("upper1", 256'h0, {128'h0, sink_u.data_q[1][255:128]});
        $display("unstraddled test done");
        reg_wr(`CSS_REG_CTRL, 32'h1);
        reg_rd(`CSS_REG_STATUS, 32'h4, 1'h0);
        slow <= 1'h1;
        seg_send(3'h6, 2'h1);
        seg_send(3'h6, 2'h3);
        wait_beats(3);
        check("side2", {1'h0, 4'hf, 4'h3, 1'h1, 1'h1}, sink_u.side_q[2][42:32]);
        check("last2", 256'h0, {255'h0, sink_u.last_q[2]});
        $display("straddle test done");
        reg_wr(`CSS_REG_CTRL, 32'h3);
        seg_send(3'h7, 2'h2);
        seg_send(3'h6, 2'h3);
        wait_beats(5);
        check("side3", {1'h1, 4'h0, 4'h5, 1'h0, 1'h1}, sink_u.side_q[3][42:32]);
        reg_rd(`CSS_REG_ABORTS, 32'h1, 1'h0);
        check("dropped", 256'h1, sink_u.dropped);
        reg_rd(`CSS_REG_BEATS, 32'h5, 1'h0);
        $display("abort test done");
        complete_run();
    end
endmodule : tb_completion_stream_sideband
